// File: design/isp_prg.sv
`timescale 1ns/1ns
`default_nettype none
module isp_prg import isp_pkg::*; #(
  parameter int SCK_HALF = SCK_HALF_DEF,
  parameter int PWRUP_CYC = PWRUP_CYC_DEF,
  parameter int WD_FLASH_CYC = WD_FLASH_CYC_DEF,
  parameter int WD_EEPROM_CYC = WD_EEPROM_CYC_DEF,
  parameter int WD_ERASE_CYC = WD_ERASE_CYC_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic session_en,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic enabled,
  isp_if.prg link
);
  if (SCK_HALF < SCK_HALF_MIN || SCK_HALF < SCK_MIN_PHASE_CYC + 1 || PWRUP_CYC < 1 || WD_ERASE_CYC >= (1 << TMR_W)
      || PWRUP_CYC >= (1 << TMR_W)) begin : g_bad
    $error("programmer timing parameters out of range");
  end

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_PULSE = 3'b001,
    ST_PWRUP = 3'b010,
    ST_SHIFT = 3'b011,
    ST_WAIT = 3'b100,
    ST_IDLE = 3'b101
  } isp_pst_e;

  isp_pst_e st_r;
  logic [TMR_W-1:0] cnt_r;
  logic [4:0] bit_r;
  logic [31:0] word_r;
  logic [31:0] rxw_r;
  logic [31:0] sent_r;
  logic pe_ok_r;
  logic rst_r;
  logic sck_r;
  logic sdi_r;
  logic sdo_a_r;
  logic sdo_b_r;
  logic pop_r;
  logic rsp_valid_r;
  logic [7:0] rsp_data_r;

  wire fifo_valid;
  wire [31:0] fifo_data;

  isp_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(cmd_valid),
    .in_data(cmd_data),
    .in_ready(cmd_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(pop_r)
  );

  // no busy polling here: each write simply waits its worst case
  function automatic logic [TMR_W-1:0] wait_cyc(input logic [31:0] w);
    if (w[31:24] == OP_WR_PAGE) return TMR_W'(WD_FLASH_CYC); // see (R16)
    if (w[31:24] == OP_WR_EE) return TMR_W'(WD_EEPROM_CYC); // see (R17)
    if (w[31:24] == OP_PROG_EN && w[23:16] == CE_KEY) return TMR_W'(WD_ERASE_CYC); // see (R18)
    return TMR_W'(GAP_CYC);
  endfunction

  wire half_done = (cnt_r == '0);
  // enable word always goes first after every reset pulse
  wire start_pe = (st_r == ST_PWRUP) && half_done; // see (R02) (R09)
  wire start_cmd = (st_r == ST_IDLE) && fifo_valid && !pop_r; // see (R13)
  wire start = start_pe || start_cmd;
  wire [31:0] start_word = start_pe ? PE_WORD : fifo_data; // see (R21)
  wire last_fall = (st_r == ST_SHIFT) && half_done && sck_r && (bit_r == 5'h1f);

  assign link.prog_rst_n = rst_r;
  assign link.sck = sck_r;
  assign link.serial_prog_data_in = sdi_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign enabled = pe_ok_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sdo_a_r <= 1'b0;
      sdo_b_r <= 1'b0;
    end else begin
      sdo_a_r <= link.serial_prog_data_out;
      sdo_b_r <= sdo_a_r;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_OFF;
      cnt_r <= '0;
      bit_r <= '0;
      word_r <= '0;
      rxw_r <= '0;
      sent_r <= '0;
      pe_ok_r <= 1'b0;
      rst_r <= 1'b1;
      sck_r <= 1'b0;
      sdi_r <= 1'b0;
      pop_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= '0;
    end else begin
      pop_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      if (!half_done) begin
        cnt_r <= cnt_r - 1'b1;
      end
      case (st_r)
        ST_OFF: begin
          if (session_en) begin
            st_r <= ST_PULSE;
            cnt_r <= TMR_W'(RST_PULSE_CYC - 1);
          end
        end
        ST_PULSE: begin
          // clock already low, reset held high for the pulse
          if (half_done) begin
            rst_r <= 1'b0; // see (R08) (R01)
            st_r <= ST_PWRUP;
            cnt_r <= TMR_W'(PWRUP_CYC - 1);
          end
        end
        ST_SHIFT: begin
          if (half_done && !sck_r) begin
            sck_r <= 1'b1;
            rxw_r <= {rxw_r[30:0], sdo_b_r};
            cnt_r <= TMR_W'(SCK_HALF - 1);
          end else if (half_done && bit_r != 5'h1f) begin
            sck_r <= 1'b0;
            bit_r <= bit_r + 5'h01;
            sdi_r <= word_r[31]; // see (R23)
            word_r <= {word_r[30:0], 1'b0};
            cnt_r <= TMR_W'(SCK_HALF - 1);
          end
        end
        ST_WAIT: begin
          if (half_done) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
        end
      endcase
      if (last_fall) begin
        sck_r <= 1'b0;
        sdi_r <= 1'b0;
        if (!pe_ok_r && rxw_r[15:8] != PE_KEY) begin
          rst_r <= 1'b1; // see (R11)
          st_r <= ST_PULSE;
          cnt_r <= TMR_W'(RST_PULSE_CYC - 1);
        end else if (!pe_ok_r) begin
          pe_ok_r <= 1'b1; // see (R10)
          st_r <= ST_WAIT;
          cnt_r <= TMR_W'(GAP_CYC);
        end else begin
          pop_r <= 1'b1;
          rsp_valid_r <= 1'b1;
          rsp_data_r <= rxw_r[7:0]; // see (R19)
          st_r <= ST_WAIT;
          cnt_r <= wait_cyc(sent_r);
        end
      end
      if (start) begin
        st_r <= ST_SHIFT;
        sent_r <= start_word;
        sdi_r <= start_word[31];
        word_r <= {start_word[30:0], 1'b0};
        bit_r <= '0;
        sck_r <= 1'b0;
        cnt_r <= TMR_W'(SCK_HALF - 1);
      end
      if (!session_en) begin
        st_r <= ST_OFF; // see (R20)
        rst_r <= 1'b1;
        sck_r <= 1'b0;
        sdi_r <= 1'b0;
        pe_ok_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: design/isp_pkg.sv
package isp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int WORD_BITS = 32;
  localparam int TMR_W = 24;

  localparam logic [7:0] OP_PROG_EN = 8'hac;
  localparam logic [7:0] PE_KEY = 8'h53;
  localparam logic [7:0] CE_KEY = 8'h80;
  localparam logic [7:0] OP_POLL = 8'hf0;
  localparam logic [7:0] OP_LD_EXT = 8'h4d;
  localparam logic [7:0] OP_LD_HI = 8'h48;
  localparam logic [7:0] OP_LD_LO = 8'h40;
  localparam logic [7:0] OP_RD_HI = 8'h28;
  localparam logic [7:0] OP_RD_LO = 8'h20;
  localparam logic [7:0] OP_RD_EE = 8'ha0;
  localparam logic [7:0] OP_RD_SIG = 8'h30;
  localparam logic [7:0] OP_RD_LOCK = 8'h58;
  localparam logic [7:0] OP_RD_FUSE = 8'h50;
  localparam logic [7:0] OP_RD_CAL = 8'h38;
  localparam logic [7:0] OP_WR_PAGE = 8'h4c;
  localparam logic [7:0] OP_WR_EE = 8'hc0;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [31:0] PE_WORD = {OP_PROG_EN, PE_KEY, 8'h00, 8'h00};

  localparam real T_WD_FLASH_MS = 4.5;
  localparam real T_WD_EEPROM_MS = 3.6;
  localparam real T_WD_ERASE_MS = 9.0;
  localparam real T_PWRUP_MS = 20.0;
  localparam int WD_FLASH_CYC_DEF = int'($ceil(T_WD_FLASH_MS * 1000.0 * CLK_MHZ));
  localparam int WD_EEPROM_CYC_DEF = int'($ceil(T_WD_EEPROM_MS * 1000.0 * CLK_MHZ));
  localparam int WD_ERASE_CYC_DEF = int'($ceil(T_WD_ERASE_MS * 1000.0 * CLK_MHZ));
  localparam int PWRUP_CYC_DEF = int'($ceil(T_PWRUP_MS * 1000.0 * CLK_MHZ));

  localparam int RST_PULSE_CYC = 2;
  localparam int SCK_MIN_PHASE_CYC = 3;
  localparam int SCK_HALF_MIN = 8;
  localparam int SCK_HALF_DEF = 8;
  localparam int GAP_CYC = 16;

  localparam int FLASH_AW_DEF = 8;
  localparam int EE_AW_DEF = 6;
  localparam int PAGE_AW_DEF = 7;
  localparam int FIFO_DEPTH_DEF = 32;
endpackage

// File: design/isp_if.sv
`timescale 1ns/1ns
`default_nettype none
interface isp_if;
  logic prog_rst_n;
  logic sck;
  logic serial_prog_data_in;
  logic serial_prog_data_out;
  modport dev (
    input prog_rst_n,
    input sck,
    input serial_prog_data_in,
    output serial_prog_data_out
  );
  modport prg (
    output prog_rst_n,
    output sck,
    output serial_prog_data_in,
    input serial_prog_data_out
  );
endinterface
`default_nettype wire

// File: design/isp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module isp_fifo import isp_pkg::*; #(
  parameter int WIDTH = WORD_BITS,
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic in_ready_r;

  wire push = in_valid && in_ready_r;
  wire pop = out_valid && out_ready;
  wire [AW:0] count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign in_ready = in_ready_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_r <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      count_r <= count_nxt;
      // registered full keeps the ready output glitch free
      in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: design/isp_dev.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// (R01) programming only while reset pin held low
// (R02) enable instruction must precede any program/erase
// (R03) eeprom write erases then writes, self-timed
// (R04) chip erase sets flash and eeprom to ff
// (R05) serial clock phases exceed minimum core cycles
// (R06) input bit taken on serial clock rise
// (R07) output bit shifted on serial clock fall
// (R08) power-up: clock low, reset pulsed high
// (R09) wait 20 ms before enable instruction
// (R10) echo second enable byte during third byte
// (R11) bad echo: send all, pulse reset, retry
// (R12) page buffer loaded bytewise with word address
// (R13) low byte loaded before high byte
// (R14) page write uses address high and extended
// (R15) extended address byte kept until reloaded
// (R16) wait 4.5 ms after flash page write
// (R17) eeprom bytewise write, wait 3.6 ms
// (R18) wait 9.0 ms after chip erase
// (R19) read returns location, flash uses extended byte
// (R20) reset released high ends the session
// (R21) enable instruction is ac 53 00 00
// (R22) poll f0 returns busy in bit 0
// (R23) msb first; traffic ignored outside reset low
// (R24) busy from start to end of self-timed op
module isp_dev import isp_pkg::*; #(
  parameter int FLASH_AW = FLASH_AW_DEF,
  parameter int EE_AW = EE_AW_DEF,
  parameter int PAGE_AW = PAGE_AW_DEF,
  parameter int WD_FLASH_CYC = WD_FLASH_CYC_DEF,
  parameter int WD_EEPROM_CYC = WD_EEPROM_CYC_DEF,
  parameter int WD_ERASE_CYC = WD_ERASE_CYC_DEF,
  // identification and fuse values below are arbitrary
  parameter logic [7:0] SIG_B0 = 8'h1e,
  parameter logic [7:0] SIG_B1 = 8'h2d,
  parameter logic [7:0] SIG_B2 = 8'h3c,
  parameter logic [7:0] FUSE_BYTE = 8'hff,
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic core_clk,
  input wire logic resetn,
  isp_if.dev link
);
  if (PAGE_AW < 1 || PAGE_AW > 7 || FLASH_AW <= PAGE_AW || FLASH_AW > 24 || EE_AW < 1 || EE_AW > 12
      || WD_ERASE_CYC >= (1 << TMR_W) || WD_FLASH_CYC < 1 || WD_EEPROM_CYC < 1) begin : g_bad
    $error("device size or timing parameters out of range");
  end

  localparam int FLASH_WORDS = 1 << FLASH_AW;
  localparam int EE_BYTES = 1 << EE_AW;
  localparam int PAGE_WORDS = 1 << PAGE_AW;

  function automatic logic [EE_AW-1:0] ee_idx(input logic [7:0] hi, input logic [7:0] lo);
    logic [11:0] a;
    a = {hi[3:0], lo};
    return a[EE_AW-1:0];
  endfunction

  logic [2:0] sync_a_r;
  logic [2:0] sync_b_r;
  logic sck_d_r;
  logic [4:0] bitcnt_r;
  logic [31:0] rx_r;
  logic [7:0] tx_r;
  logic sdo_r;
  logic prog_en_r;
  logic [7:0] ext_r;
  logic [TMR_W-1:0] tmr_r;
  logic [15:0] flash_mem [FLASH_WORDS];
  logic [15:0] pbuf [PAGE_WORDS];
  logic [7:0] ee_mem [EE_BYTES];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync_a_r <= 3'h4;
      sync_b_r <= 3'h4;
      sck_d_r <= 1'b0;
    end else begin
      sync_a_r <= {link.prog_rst_n, link.sck, link.serial_prog_data_in};
      sync_b_r <= sync_a_r;
      sck_d_r <= sync_b_r[1];
    end
  end

  // pins are asynchronous; all decoding looks only at the second stage and at sck_d_r, a delayed copy of its clock bit
  wire in_prog = !sync_b_r[2]; // see (R01) (R20)
  wire sck_rise = in_prog && sync_b_r[1] && !sck_d_r; // see (R23)
  wire sck_fall = in_prog && !sync_b_r[1] && sck_d_r;
  wire [31:0] rx_nxt = {rx_r[30:0], sync_b_r[0]};
  wire word_done = sck_rise && (bitcnt_r == 5'h1f);

  wire [7:0] c1 = rx_nxt[31:24];
  wire [7:0] c2 = rx_nxt[23:16];
  wire [7:0] c3 = rx_nxt[15:8];
  wire [7:0] c4 = rx_nxt[7:0];
  wire program_ready_flag = (tmr_r == '0);
  wire pe_hit = word_done && c1 == OP_PROG_EN && c2 == PE_KEY;
  // writes during a self-timed op are dropped rather than corrupting it
  wire accept = word_done && prog_en_r && program_ready_flag; // see (R02)
  wire ld_ext = accept && c1 == OP_LD_EXT;
  wire ld_lo = accept && c1 == OP_LD_LO;
  wire ld_hi = accept && c1 == OP_LD_HI;
  wire wr_page = accept && c1 == OP_WR_PAGE;
  wire wr_ee = accept && c1 == OP_WR_EE;
  wire erase = accept && c1 == OP_PROG_EN && c2 == CE_KEY;
  wire [23:0] wr_addr = {ext_r, c2, c3}; // see (R14)
  wire [EE_AW-1:0] wr_eidx = ee_idx(c2, c3);

  wire [7:0] q1 = rx_r[23:16];
  wire [7:0] q2 = rx_r[15:8];
  wire [7:0] q3 = rx_r[7:0];
  wire [23:0] rd_addr = {ext_r, q2, q3}; // see (R19)
  wire [15:0] rd_word = flash_mem[rd_addr[FLASH_AW-1:0]];
  wire [7:0] rd_ee = ee_mem[ee_idx(q2, q3)];
  wire [7:0] rd_sig = (q3[1:0] == 2'h0) ? SIG_B0 : (q3[1:0] == 2'h1) ? SIG_B1 : (q3[1:0] == 2'h2) ? SIG_B2 : 8'h00;
  wire [7:0] rd_data = !prog_en_r ? 8'h00 :
                       (q1 == OP_RD_LO) ? rd_word[7:0] :
                       (q1 == OP_RD_HI) ? rd_word[15:8] :
                       (q1 == OP_RD_EE) ? rd_ee :
                       (q1 == OP_POLL) ? {7'h00, !program_ready_flag} : // see (R22)
                       (q1 == OP_RD_SIG) ? rd_sig :
                       (q1 == OP_RD_LOCK || q1 == OP_RD_FUSE) ? FUSE_BYTE :
                       (q1 == OP_RD_CAL) ? CAL_BYTE : 8'h00;
  // bytes 2 and 3 echo the byte just received; byte 4 carries read data
  wire [1:0] out_idx = bitcnt_r[4:3];
  wire [7:0] reply = (out_idx == 2'h3) ? rd_data : (out_idx == 2'h0) ? 8'h00 : q3; // see (R10)

  assign link.serial_prog_data_out = sdo_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bitcnt_r <= '0;
      rx_r <= '0;
      tx_r <= '0;
      sdo_r <= 1'b0;
    end else if (!in_prog) begin
      bitcnt_r <= '0;
      rx_r <= '0;
      tx_r <= '0;
      sdo_r <= 1'b0;
    end else if (sck_rise) begin
      rx_r <= rx_nxt; // see (R06)
      bitcnt_r <= bitcnt_r + 5'h01;
    end else if (sck_fall && bitcnt_r[2:0] == 3'h0) begin
      sdo_r <= reply[7]; // see (R07)
      tx_r <= {reply[6:0], 1'b0};
    end else if (sck_fall) begin
      sdo_r <= tx_r[7];
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prog_en_r <= 1'b0;
      ext_r <= '0;
      tmr_r <= '0;
    end else begin
      if (!in_prog) begin
        prog_en_r <= 1'b0; // see (R20)
      end else if (pe_hit) begin
        prog_en_r <= 1'b1; // see (R21)
      end
      if (ld_ext) begin
        ext_r <= c3; // see (R15)
      end
      // the op keeps running even if reset is released meanwhile
      if (wr_page) begin
        tmr_r <= TMR_W'(WD_FLASH_CYC); // see (R24)
      end else if (wr_ee) begin
        tmr_r <= TMR_W'(WD_EEPROM_CYC);
      end else if (erase) begin
        tmr_r <= TMR_W'(WD_ERASE_CYC);
      end else if (!program_ready_flag) begin
        tmr_r <= tmr_r - 1'b1;
      end
    end
  end

  for (genvar gp = 0; gp < PAGE_WORDS; gp++) begin : g_pbuf
    wire hit = (c3[PAGE_AW-1:0] == PAGE_AW'(gp));
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        pbuf[gp] <= {ERASED, ERASED};
      end else if (ld_lo && hit) begin
        pbuf[gp][7:0] <= c4; // see (R12)
      end else if (ld_hi && hit) begin
        pbuf[gp][15:8] <= c4;
      end
    end
  end

  for (genvar gf = 0; gf < FLASH_WORDS; gf++) begin : g_flash
    localparam logic [FLASH_AW-1:0] IDX = FLASH_AW'(gf);
    wire page_hit = wr_page && (wr_addr[FLASH_AW-1:PAGE_AW] == IDX[FLASH_AW-1:PAGE_AW]);
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        flash_mem[gf] <= {ERASED, ERASED};
      end else if (erase) begin
        flash_mem[gf] <= {ERASED, ERASED}; // see (R04)
      end else if (page_hit) begin
        flash_mem[gf] <= pbuf[IDX[PAGE_AW-1:0]]; // see (R14)
      end
    end
  end

  for (genvar ge = 0; ge < EE_BYTES; ge++) begin : g_ee
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        ee_mem[ge] <= ERASED;
      end else if (erase) begin
        ee_mem[ge] <= ERASED; // see (R04)
      end else if (wr_ee && wr_eidx == EE_AW'(ge)) begin
        // erase-then-write collapses into one store; timer models the cycle
        ee_mem[ge] <= c4; // see (R03) (R17)
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/isp_checker.sv
`timescale 1ns/1ns
`default_nettype none
module isp_checker import isp_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic prog_rst_n,
  input wire logic sck,
  input wire logic serial_prog_data_in,
  input wire logic serial_prog_data_out
);
  logic sck_r, fresh_r, first_r;
  logic [4:0] cnt_r;
  logic [31:0] din_r;
  logic [7:0] dout_r;
  wire logic rise = sck & ~sck_r;
  wire logic word_end = fresh_r && cnt_r == 5'h0;
  // link bits seen at each sck rise, framed from the fall of prog_rst_n
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sck_r <= 1'b0;
      fresh_r <= 1'b0;
      first_r <= 1'b1;
      cnt_r <= 5'h0;
      din_r <= 32'h0;
      dout_r <= 8'h0;
    end else begin
      sck_r <= sck;
      fresh_r <= rise & ~prog_rst_n;
      if (prog_rst_n) begin
        cnt_r <= 5'h0;
        first_r <= 1'b1;
      end else if (rise) begin
        cnt_r <= cnt_r + 5'h1;
        din_r <= {din_r[30:0], serial_prog_data_in};
        dout_r <= {dout_r[6:0], serial_prog_data_out};
      end
      if (word_end && !prog_rst_n) first_r <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_sck_high_min: assert property ($rose(sck) |-> sck [*3])
    else $error("sck high phase too short");
  a_sck_low_min: assert property ($fell(sck) |-> !sck [*3])
    else $error("sck low phase too short");
  a_din_hold_high: assert property (sck && $past(sck) |-> $stable(serial_prog_data_in))
    else $error("data in moved while sck high");
  a_dout_fall_only: assert property (sck && $past(sck, 4) && !prog_rst_n |-> $stable(serial_prog_data_out))
    else $error("data out moved away from sck fall");
  a_sck_quiet_idle: assert property (prog_rst_n |-> !sck)
    else $error("sck active outside session");
  a_dout_ignored_idle: assert property (prog_rst_n && $past(prog_rst_n, 4) |-> $stable(serial_prog_data_out))
    else $error("data out moved outside session");
  a_rst_pulse_min: assert property ($rose(prog_rst_n) |-> prog_rst_n [*2])
    else $error("reset pulse too short");
  a_echo_enable_key: assert property (fresh_r && cnt_r == 5'h18 && din_r[23:8] == {OP_PROG_EN, PE_KEY}
    |-> dout_r == PE_KEY)
    else $error("enable key not echoed");
  a_enable_first_word: assert property (word_end && first_r |-> din_r == PE_WORD)
    else $error("first word of session is not enable");
  cover property (fresh_r && cnt_r == 5'h18 && dout_r == PE_KEY);
  cover property ($rose(prog_rst_n));
  cover property (word_end && din_r[31:24] == OP_POLL);
  cover property (word_end && din_r[31:24] == OP_WR_PAGE);
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb import isp_pkg::*;;
  localparam int PG = 1 << PAGE_AW_DEF;
  localparam int EM = (1 << EE_AW_DEF) - 1;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic session_en = 1'b0;
  logic cmd_valid = 1'b0;
  logic [31:0] cmd_data = 32'h0;
  logic cmd_ready, rsp_valid, enabled;
  logic [7:0] rsp_data;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [8:0] exp_q[$];
  logic [7:0] ee_m[int];
  logic [15:0] fl_m[int];
  logic [15:0] pb[int];

  // flash and erase waits shared, so both ends always agree on them
  localparam int T_FLASH = 40;
  localparam int T_ERASE = 80;
  isp_if u_isp_if ();
  isp_prg #(.PWRUP_CYC(50), .WD_FLASH_CYC(T_FLASH), .WD_EEPROM_CYC(30), .WD_ERASE_CYC(T_ERASE)) u_isp_prg (
    .core_clk(core_clk), .resetn(resetn), .session_en(session_en), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .enabled(enabled), .link(u_isp_if.prg));
  // eeprom busy outlasts the programmer's wait, so only polling keeps writes safe
  isp_dev #(.WD_FLASH_CYC(T_FLASH), .WD_EEPROM_CYC(600), .WD_ERASE_CYC(T_ERASE)) u_isp_dev (
    .core_clk(core_clk), .resetn(resetn), .link(u_isp_if.dev));
  isp_checker u_isp_checker (
    .core_clk(core_clk), .resetn(resetn), .prog_rst_n(u_isp_if.prog_rst_n), .sck(u_isp_if.sck),
    .serial_prog_data_in(u_isp_if.serial_prog_data_in), .serial_prog_data_out(u_isp_if.serial_prog_data_out));

  always #5 core_clk = ~core_clk;

  task print_verdict;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      print_verdict();
    end
  end

  always @(posedge core_clk) begin
    if (rsp_valid === 1'b1 && exp_q.size() == 0) chk("response count", 8'h0, 8'h1);
    else if (rsp_valid === 1'b1 && exp_q[0][8]) chk("rsp_data", exp_q[0][7:0], rsp_data);
    if (rsp_valid === 1'b1 && exp_q.size() > 0) void'(exp_q.pop_front());
  end

  function logic [8:0] eexp(input int a);
    return {1'b1, ee_m.exists(a) ? ee_m[a] : ERASED};
  endfunction
  function logic [8:0] fexp(input int a, input bit hi);
    logic [15:0] v;
    v = fl_m.exists(a) ? fl_m[a] : {ERASED, ERASED};
    return {1'b1, hi ? v[15:8] : v[7:0]};
  endfunction
  function logic [31:0] rd_ee(input int a);
    return {OP_RD_EE, 4'h0, 4'(a >> 8), 8'(a), 8'h00};
  endfunction

  task push(input logic [31:0] w, input logic [8:0] e);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_data <= w;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 40000);
    exp_q.push_back(e);
    cmd_valid <= 1'b0;
    @(posedge core_clk);
  endtask

  task drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 60000) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  task wait_en(input logic v);
    int n;
    n = 0;
    while (enabled !== v && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    chk("enabled", {7'h0, v}, {7'h0, enabled});
  endtask

  task ee_wr(input int a, input logic [7:0] d);
    push({OP_WR_EE, 4'h0, 4'(a >> 8), 8'(a), d}, 9'h0);
    ee_m[a] = d;
    push({OP_POLL, 24'h0}, 9'h101);
    push({OP_POLL, 24'h0}, 9'h100);
  endtask
  task fl_ld(input int a, input logic [15:0] d);
    push({OP_LD_LO, 8'h00, 8'(a % PG), d[7:0]}, 9'h0);
    push({OP_LD_HI, 8'h00, 8'(a % PG), d[15:8]}, 9'h0);
    pb[a % PG] = d;
  endtask
  task fl_wr(input int pg);
    push({OP_WR_PAGE, 8'h00, 8'(pg * PG), 8'h00}, 9'h0);
    foreach (pb[o]) fl_m[pg * PG + o] = pb[o];
  endtask
  task fl_rd(input int a);
    push({OP_RD_LO, 8'(a >> 8), 8'(a), 8'h00}, fexp(a, 1'b0));
    push({OP_RD_HI, 8'(a >> 8), 8'(a), 8'h00}, fexp(a, 1'b1));
  endtask

  initial begin
    int a;
    int taken;
    void'($urandom(42));
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    session_en <= 1'b1;
    wait_en(1'b1);
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? 0 : (i == 1) ? EM : $urandom_range(EM);
      ee_wr(a, 8'($urandom));
    end
    // inverted rewrite needs 0 to 1 flips, only an inner erase gives those
    ee_wr(a, ~ee_m[a]);
    foreach (ee_m[k]) push(rd_ee(k), eexp(k));
    push({OP_LD_EXT, 24'h0}, 9'h0);
    fl_ld(0, 16'($urandom));
    fl_ld(PG - 1, 16'($urandom));
    fl_ld($urandom_range(PG - 1), 16'($urandom));
    fl_wr(0);
    fl_ld(PG, 16'($urandom));
    fl_ld(2 * PG - 1, 16'($urandom));
    fl_wr(1);
    foreach (fl_m[k]) fl_rd(k);
    push({OP_PROG_EN, CE_KEY, 16'h0}, 9'h0);
    fl_m.delete();
    ee_m.delete();
    fl_rd(PG - 1);
    push(rd_ee(EM), eexp(EM));
    a = $urandom_range(EM);
    ee_wr(a, 8'($urandom));
    drain();
    session_en <= 1'b0;
    wait_en(1'b0);
    chk("prog_rst_n", 8'h1, {7'h0, u_isp_if.prog_rst_n});
    taken = 0;
    cmd_valid <= 1'b1;
    cmd_data <= rd_ee(a);
    repeat (40) begin
      @(posedge core_clk);
      if (cmd_ready === 1'b1) begin
        exp_q.push_back(eexp(cmd_data[15:8]));
        taken++;
        cmd_data <= rd_ee(taken[0] ? $urandom_range(EM) : a);
      end
    end
    cmd_valid <= 1'b0;
    chk("fifo words taken", 8'(FIFO_DEPTH_DEF), 8'(taken));
    session_en <= 1'b1;
    drain();
    // a drain that ran out leaves answers owed: that is a mismatch too
    if (exp_q.size() != 0) chk("responses left", 8'h00, 8'(exp_q.size()));
    print_verdict();
  end
endmodule
`default_nettype wire
